// ===== src/sync_pll_mode_control.sv
// Mode control, offset slewing and status for a synchronising PLL.
//
// Behaviour
// - Outputs shifted by fine offset, 477 ps steps.
// - Fine offset is signed two's complement.
// - Phase slew limited by filter corner selection.
// - Primary reference rate code at bits 4-3.
// - Secondary reference rate code at bits 4-3.
// - Loop holdover flag on loss, drift, hit.
// - Loop range flag when capture range exceeded.
// - 32-bit calibration word, four bytes, MSB first.
// - Frequency offset beyond limit declares failure.
// - Half-cycle phase hit fails, except 8 kHz.
// - Failure forces auto-holdover, lock 0, holdover 1.
// - Auto return after enough hit-free cycles.
// - Inhibited return needs manual release rising edge.
// - Reset to free-run; normal without reference holds.
// - Holdover keeps free-run output accuracy.
// - Loop synchronised then core acquires, locks, normal.
// - Reference switch in auto-holdover goes via holdover.
// - Frequency steered below 2.0 ppm/s slope.
// - Auto-holdover to normal without phase hit.
// - Mode codes normal, holdover, free-run, reserved.
// - Lock bit high only while core locked.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
module sync_pll_mode_control #(
   parameter logic [13:0] SLEW_HI_CYCLES =
      14'(pll_mode_pkg::SLEW_HI_CYCLES),
   parameter logic [19:0] FREQ_STEP_CYCLES =
      20'(pll_mode_pkg::FREQ_STEP_CYCLES)
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register port
   input wire logic [6:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   // Primary reference front end
   input wire logic pri_ref_cycle,
   input wire logic pri_freq_fail,
   input wire logic pri_phase_hit,
   input wire logic pri_range_exceed,
   input wire logic [1:0] pri_rate_code,
   // Secondary reference front end
   input wire logic sec_ref_cycle,
   input wire logic sec_freq_fail,
   input wire logic sec_phase_hit,
   input wire logic sec_range_exceed,
   input wire logic [1:0] sec_rate_code,
   // Frequency of the selected reference, 0.1 ppm units, signed
   input wire logic [15:0] selected_ref_freq,
   // Status and core outputs
   output logic lock,
   output logic holdover,
   output logic free_run,
   output logic [7:0] phase_offset,
   output logic [15:0] core_freq,
   output logic [31:0] osc_calibration_word
);
   localparam logic [13:0] SLEW_LO_CYCLES =
      14'(pll_mode_pkg::SLEW_LO_CYCLES);

   typedef struct packed {
      logic reference_choice;
      logic ref_prev;
      logic [1:0] operating_mode_select;
      logic filter_corner_select;
      logic auto_return_inhibit;
      logic manual_release;
      logic [7:0] fine_phase_step;
      logic [7:0] phase;
      logic [13:0] slew_cnt;
      logic [15:0] freq;
      logic [19:0] freq_cnt;
      logic [31:0] cal;
      pll_mode_pkg::core_state_type state;
      logic lock;
      logic holdover;
      logic free_run;
      logic [7:0] rdata;
   } regs_type;

   regs_type q;
   regs_type d;

   logic pri_hold;
   logic pri_range;
   logic sec_hold;
   logic sec_range;
   logic sel_hold;
   logic sel_range;
   logic ref_switch;
   logic release_rise;
   logic [13:0] slew_limit;
   logic [15:0] freq_target;
   logic tracking;

   ref_monitor pri_mon (
      .clk(clk),
      .reset(reset),
      .ref_cycle(pri_ref_cycle),
      .freq_fail(pri_freq_fail),
      .phase_hit(pri_phase_hit),
      .range_exceed(pri_range_exceed),
      .rate_code(pri_rate_code),
      .holdover_flag(pri_hold),
      .range_flag(pri_range)
   );

   ref_monitor sec_mon (
      .clk(clk),
      .reset(reset),
      .ref_cycle(sec_ref_cycle),
      .freq_fail(sec_freq_fail),
      .phase_hit(sec_phase_hit),
      .range_exceed(sec_range_exceed),
      .rate_code(sec_rate_code),
      .holdover_flag(sec_hold),
      .range_flag(sec_range)
   );

   always_comb begin
      d = q;
      d.rdata = 8'h00;
      sel_hold = q.reference_choice ? sec_hold : pri_hold;
      sel_range = q.reference_choice ? sec_range : pri_range;
      ref_switch = (q.ref_prev != q.reference_choice);
      d.ref_prev = q.reference_choice;
      release_rise = wr && (addr == pll_mode_pkg::ADDR_RELEASE)
         && wdata[pll_mode_pkg::REL_MANUAL_BIT] && !q.manual_release;

      // Register writes.
      if (wr) begin
         unique case (addr)
            pll_mode_pkg::ADDR_CTRL: begin
               d.reference_choice = wdata[pll_mode_pkg::CTRL_REF_BIT];
               d.operating_mode_select =
                  wdata[pll_mode_pkg::CTRL_MODE_HI:pll_mode_pkg::CTRL_MODE_LO];
               d.filter_corner_select =
                  wdata[pll_mode_pkg::CTRL_CORNER_BIT];
            end
            pll_mode_pkg::ADDR_RELEASE: begin
               d.manual_release = wdata[pll_mode_pkg::REL_MANUAL_BIT];
               d.auto_return_inhibit = wdata[pll_mode_pkg::REL_INHIBIT_BIT];
            end
            pll_mode_pkg::ADDR_FINE: d.fine_phase_step = wdata;
            pll_mode_pkg::ADDR_CAL3: d.cal[31:24] = wdata;
            pll_mode_pkg::ADDR_CAL2: d.cal[23:16] = wdata;
            pll_mode_pkg::ADDR_CAL1: d.cal[15:8] = wdata;
            pll_mode_pkg::ADDR_CAL0: d.cal[7:0] = wdata;
            default: ;
         endcase
      end

      // Register reads; unmapped offsets read as zero.
      if (rd) begin
         unique case (addr)
            pll_mode_pkg::ADDR_CTRL:
               d.rdata = {q.reference_choice, 2'h0,
                          q.operating_mode_select,
                          q.filter_corner_select, 2'h0};
            pll_mode_pkg::ADDR_STATUS:
               d.rdata = {2'h0, q.lock, q.holdover, 1'b0, sel_range, 2'h0};
            pll_mode_pkg::ADDR_RELEASE:
               d.rdata = {5'h00, q.manual_release,
                          q.auto_return_inhibit, 1'b0};
            pll_mode_pkg::ADDR_FINE: d.rdata = q.fine_phase_step;
            pll_mode_pkg::ADDR_PRI_ACQ:
               d.rdata = {3'h0, pri_rate_code, 1'b0,
                          pri_hold, pri_range};
            pll_mode_pkg::ADDR_SEC_ACQ:
               d.rdata = {3'h0, sec_rate_code, 1'b0,
                          sec_hold, sec_range};
            pll_mode_pkg::ADDR_CAL3: d.rdata = q.cal[31:24];
            pll_mode_pkg::ADDR_CAL2: d.rdata = q.cal[23:16];
            pll_mode_pkg::ADDR_CAL1: d.rdata = q.cal[15:8];
            pll_mode_pkg::ADDR_CAL0: d.rdata = q.cal[7:0];
            default: d.rdata = 8'h00;
         endcase
      end

      // Core loop state machine; the reserved mode code freezes it.
      unique case (q.operating_mode_select)
         pll_mode_pkg::MODE_FREE_RUN: d.state = pll_mode_pkg::ST_FREE_RUN;
         pll_mode_pkg::MODE_HOLDOVER: d.state = pll_mode_pkg::ST_HOLDOVER;
         pll_mode_pkg::MODE_NORMAL: begin
            unique case (q.state)
               pll_mode_pkg::ST_FREE_RUN:
                  d.state = pll_mode_pkg::ST_HOLDOVER;
               pll_mode_pkg::ST_HOLDOVER: begin
                  // Waits here for as long as the selected reference is unusable.
                  if (!sel_hold) begin
                     d.state = pll_mode_pkg::ST_ACQUIRE;
                  end
               end
               pll_mode_pkg::ST_ACQUIRE: begin
                  if (sel_hold) begin
                     d.state = pll_mode_pkg::ST_HOLDOVER;
                  end else if (q.freq == selected_ref_freq) begin
                     d.state = pll_mode_pkg::ST_NORMAL;
                  end
               end
               pll_mode_pkg::ST_NORMAL: begin
                  if (ref_switch) begin
                     d.state = pll_mode_pkg::ST_HOLDOVER;
                  end else if (sel_hold) begin
                     d.state = pll_mode_pkg::ST_AUTO_HOLDOVER;
                  end
               end
               pll_mode_pkg::ST_AUTO_HOLDOVER: begin
                  if (ref_switch) begin
                     d.state = pll_mode_pkg::ST_HOLDOVER;
                  end else if (!sel_hold && !q.auto_return_inhibit) begin
                     d.state = pll_mode_pkg::ST_NORMAL;
                  end else if (!sel_hold && release_rise) begin
                     d.state = pll_mode_pkg::ST_NORMAL;
                  end
               end
               default: d.state = pll_mode_pkg::ST_FREE_RUN;
            endcase
         end
         default: d.state = q.state;
      endcase

      d.lock = (d.state == pll_mode_pkg::ST_NORMAL);
      d.holdover = (d.state == pll_mode_pkg::ST_HOLDOVER)
         || (d.state == pll_mode_pkg::ST_AUTO_HOLDOVER);
      d.free_run = (d.state == pll_mode_pkg::ST_FREE_RUN);

      // Frequency steering: holdover freezes the last frequency, free-run
      // walks back to the bare oscillator, and every change is one unit.
      tracking = (q.state == pll_mode_pkg::ST_ACQUIRE)
         || (q.state == pll_mode_pkg::ST_NORMAL);
      freq_target = (q.state == pll_mode_pkg::ST_FREE_RUN) ? 16'h0000
         : tracking ? selected_ref_freq : q.freq;
      if (q.freq == freq_target) begin
         d.freq_cnt = 20'h00000;
      end else if (q.freq_cnt >= FREQ_STEP_CYCLES - 20'h00001) begin
         d.freq_cnt = 20'h00000;
         if ($signed(freq_target) > $signed(q.freq)) begin
            d.freq = q.freq + 16'h0001;
         end else begin
            d.freq = q.freq - 16'h0001;
         end
      end else begin
         d.freq_cnt = q.freq_cnt + 20'h00001;
      end

      // Phase slew toward the programmed offset, one fine step at a time,
      // so no state change ever jumps the output phase.
      slew_limit = q.filter_corner_select ? SLEW_HI_CYCLES : SLEW_LO_CYCLES;
      if (q.phase == q.fine_phase_step) begin
         d.slew_cnt = 14'h0000;
      end else if (q.slew_cnt >= slew_limit - 14'h0001) begin
         d.slew_cnt = 14'h0000;
         if ($signed(q.fine_phase_step) > $signed(q.phase)) begin
            d.phase = q.phase + 8'h01;
         end else begin
            d.phase = q.phase - 8'h01;
         end
      end else begin
         d.slew_cnt = q.slew_cnt + 14'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         q <= '{reference_choice: 1'b0, ref_prev: 1'b0,
                operating_mode_select: pll_mode_pkg::MODE_RESET,
                filter_corner_select: 1'b0, auto_return_inhibit: 1'b0,
                manual_release: 1'b0,
                fine_phase_step: pll_mode_pkg::FINE_RESET,
                phase: pll_mode_pkg::FINE_RESET, slew_cnt: 14'h0000,
                freq: 16'h0000, freq_cnt: 20'h00000,
                cal: {4{pll_mode_pkg::CAL_RESET}},
                state: pll_mode_pkg::ST_FREE_RUN, lock: 1'b0,
                holdover: 1'b0, free_run: 1'b1, rdata: 8'h00};
      end else begin
         q <= d;
      end
   end

   assign rdata = q.rdata;
   assign lock = q.lock;
   assign holdover = q.holdover;
   assign free_run = q.free_run;
   assign phase_offset = q.phase;
   assign core_freq = q.freq;
   assign osc_calibration_word = q.cal;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_reset_free_run: assert property (
      $fell(reset) |-> free_run && !lock && !holdover)
      else $error("device not in free-run after reset");
   a_auto_hold_flags: assert property (
      (q.state == pll_mode_pkg::ST_AUTO_HOLDOVER) |-> !lock && holdover)
      else $error("auto-holdover shows wrong lock or holdover status");
   a_fail_enters_auto: assert property (
      (q.state == pll_mode_pkg::ST_NORMAL) && sel_hold && !ref_switch
      && (q.operating_mode_select == pll_mode_pkg::MODE_NORMAL)
      |=> (q.state == pll_mode_pkg::ST_AUTO_HOLDOVER) ##0 holdover)
      else $error("reference failure did not force auto-holdover");
   a_lock_from_acquire: assert property (
      $rose(lock) |-> ($past(q.state) == pll_mode_pkg::ST_ACQUIRE)
      || ($past(q.state) == pll_mode_pkg::ST_AUTO_HOLDOVER))
      else $error("lock asserted without acquisition or release");
   a_inhibit_holds: assert property (
      (q.state == pll_mode_pkg::ST_AUTO_HOLDOVER) && q.auto_return_inhibit
      && !release_rise && !ref_switch
      && (q.operating_mode_select == pll_mode_pkg::MODE_NORMAL)
      |=> (q.state == pll_mode_pkg::ST_AUTO_HOLDOVER))
      else $error("auto-holdover left without manual release");
   a_slew_step: assert property (
      $changed(phase_offset) |-> ($past(q.slew_cnt) >= $past(slew_limit)
      - 14'h0001) && ((phase_offset - $past(phase_offset) == 8'h01)
      || ($past(phase_offset) - phase_offset == 8'h01)))
      else $error("phase moved faster than the slew limit");
   a_signed_direction: assert property (
      $changed(phase_offset) |->
      (($signed(phase_offset) > $signed($past(phase_offset)))
      == ($signed($past(q.fine_phase_step))
      > $signed($past(phase_offset)))))
      else $error("phase moved away from the signed offset");
   a_freq_slope: assert property (
      $changed(core_freq) |-> ($past(q.freq_cnt) >= FREQ_STEP_CYCLES
      - 20'h00001) && ((core_freq - $past(core_freq) == 16'h0001)
      || ($past(core_freq) - core_freq == 16'h0001)))
      else $error("core frequency stepped faster than allowed");
   a_cal_msb_write: assert property (
      wr && (addr == pll_mode_pkg::ADDR_CAL3)
      |=> (osc_calibration_word[31:24] == $past(wdata)))
      else $error("calibration high byte not stored");
   a_pri_rate_read: assert property (
      rd && (addr == pll_mode_pkg::ADDR_PRI_ACQ)
      |=> (rdata[4:3] == $past(pri_rate_code))
      ##1 ((rdata == 8'h00) || $past(rd)))
      else $error("primary rate code misreported");
   a_sec_rate_read: assert property (
      rd && (addr == pll_mode_pkg::ADDR_SEC_ACQ)
      |=> (rdata[4:3] == $past(sec_rate_code)))
      else $error("secondary rate code misreported");
endmodule // sync_pll_mode_control

// ===== src/pll_mode_pkg.sv
// Register map, field positions, reset values and timing constants.
package pll_mode_pkg;
   localparam longint CLK_PERIOD_NS = 50;

   // Register offsets.
   localparam logic [6:0] ADDR_CTRL = 7'h00;
   localparam logic [6:0] ADDR_STATUS = 7'h01;
   localparam logic [6:0] ADDR_RELEASE = 7'h19;
   localparam logic [6:0] ADDR_FINE = 7'h1a;
   localparam logic [6:0] ADDR_PRI_ACQ = 7'h20;
   localparam logic [6:0] ADDR_SEC_ACQ = 7'h28;
   localparam logic [6:0] ADDR_CAL3 = 7'h40;
   localparam logic [6:0] ADDR_CAL2 = 7'h41;
   localparam logic [6:0] ADDR_CAL1 = 7'h42;
   localparam logic [6:0] ADDR_CAL0 = 7'h43;

   // Field positions.
   localparam int CTRL_REF_BIT = 7;
   localparam int CTRL_MODE_HI = 4;
   localparam int CTRL_MODE_LO = 3;
   localparam int CTRL_CORNER_BIT = 2;
   localparam int REL_MANUAL_BIT = 2;
   localparam int REL_INHIBIT_BIT = 1;
   localparam int STAT_LOCK_BIT = 5;
   localparam int STAT_HOLD_BIT = 4;
   localparam int STAT_RANGE_BIT = 2;
   localparam int ACQ_RATE_HI = 4;
   localparam int ACQ_RATE_LO = 3;
   localparam int ACQ_HOLD_BIT = 1;
   localparam int ACQ_RANGE_BIT = 0;

   // Reset values.
   localparam logic [1:0] MODE_RESET = 2'h2;
   localparam logic [7:0] FINE_RESET = 8'h00;
   localparam logic [7:0] CAL_RESET = 8'h00;
   localparam logic ACQ_HOLD_RESET = 1'b1;

   // Mode select codes; 2'h3 is reserved.
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_HOLDOVER = 2'h1;
   localparam logic [1:0] MODE_FREE_RUN = 2'h2;

   // Reference rate codes.
   localparam logic [1:0] RATE_19M44 = 2'h0;
   localparam logic [1:0] RATE_8K = 2'h1;
   localparam logic [1:0] RATE_1M544 = 2'h2;
   localparam logic [1:0] RATE_2M048 = 2'h3;

   // Hit-free reference cycles needed before a loop leaves holdover.
   localparam logic [9:0] QUIET_FAST = 10'h040;
   localparam logic [9:0] QUIET_19M44 = 10'h200;
   localparam logic [9:0] QUIET_8K = 10'h001;

   // Missing reference edges for this long means the reference is lost.
   localparam longint LOSS_TIME_NS = 130000;
   localparam logic [11:0] LOSS_CYCLES = 12'(LOSS_TIME_NS / CLK_PERIOD_NS);

   // Phase slew: one fine step no more often than these intervals.
   localparam longint FINE_STEP_PS = 477;
   localparam longint SLEW_HI_NS = 885;
   localparam longint SLEW_HI_WINDOW_NS = 1000000000;
   localparam longint SLEW_LO_NS = 41;
   localparam longint SLEW_LO_WINDOW_NS = 1326000;
   localparam longint SLEW_HI_DEN = SLEW_HI_NS * 1000 * CLK_PERIOD_NS;
   localparam longint SLEW_LO_DEN = SLEW_LO_NS * 1000 * CLK_PERIOD_NS;
   localparam longint SLEW_HI_CYCLES =
      (FINE_STEP_PS * SLEW_HI_WINDOW_NS + SLEW_HI_DEN - 1) / SLEW_HI_DEN;
   localparam longint SLEW_LO_CYCLES =
      (FINE_STEP_PS * SLEW_LO_WINDOW_NS + SLEW_LO_DEN - 1) / SLEW_LO_DEN;

   // Frequency steering: unit of 0.1 ppm, slope limit of 2.0 ppm/s.
   localparam longint FREQ_UNIT_PPB = 100;
   localparam longint FREQ_SLOPE_PPB_PER_S = 2000;
   localparam longint FREQ_DEN = FREQ_SLOPE_PPB_PER_S * CLK_PERIOD_NS;
   localparam longint FREQ_STEP_CYCLES =
      (1000000000 * FREQ_UNIT_PPB + FREQ_DEN - 1) / FREQ_DEN;

   typedef enum logic [2:0] {
      ST_FREE_RUN,
      ST_HOLDOVER,
      ST_ACQUIRE,
      ST_NORMAL,
      ST_AUTO_HOLDOVER
   } core_state_type;
endpackage

// ===== src/ref_monitor.sv
// Acquisition loop monitor: holdover and range flags for one reference.
`timescale 1ns/1ns
module ref_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Reference front end
   input wire logic ref_cycle,
   input wire logic freq_fail,
   input wire logic phase_hit,
   input wire logic range_exceed,
   input wire logic [1:0] rate_code,
   // Flags
   output logic holdover_flag,
   output logic range_flag
);
   typedef struct packed {
      logic hold;
      logic range;
      logic [9:0] quiet;
      logic [11:0] idle;
   } mon_type;

   mon_type q;
   mon_type d;
   logic hit;
   logic lost;
   logic [9:0] need;

   always_comb begin
      d = q;
      hit = phase_hit && (rate_code != pll_mode_pkg::RATE_8K);
      if (ref_cycle) begin
         d.idle = 12'h000;
      end else if (q.idle != pll_mode_pkg::LOSS_CYCLES) begin
         d.idle = q.idle + 12'h001;
      end
      lost = (q.idle == pll_mode_pkg::LOSS_CYCLES);
      unique case (rate_code)
         pll_mode_pkg::RATE_8K: need = pll_mode_pkg::QUIET_8K;
         pll_mode_pkg::RATE_19M44: need = pll_mode_pkg::QUIET_19M44;
         pll_mode_pkg::RATE_1M544,
         pll_mode_pkg::RATE_2M048: need = pll_mode_pkg::QUIET_FAST;
      endcase
      // A fault always wins over the recovery count.
      if (freq_fail || hit || lost) begin
         d.hold = 1'b1;
         d.quiet = 10'h000;
      end else if (ref_cycle && q.hold) begin
         if (q.quiet + 10'h001 >= need) begin
            d.hold = 1'b0;
            d.quiet = 10'h000;
         end else begin
            d.quiet = q.quiet + 10'h001;
         end
      end
      d.range = range_exceed;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         q <= '{hold: pll_mode_pkg::ACQ_HOLD_RESET, range: 1'b0,
                quiet: 10'h000, idle: 12'h000};
      end else begin
         q <= d;
      end
   end

   assign holdover_flag = q.hold;
   assign range_flag = q.range;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_fault_sets_hold: assert property (
      freq_fail |=> holdover_flag)
      else $error("frequency failure did not raise holdover flag");
   a_hit_8k_ignored: assert property (
      (rate_code == pll_mode_pkg::RATE_8K) && phase_hit && !freq_fail
      && !lost && ref_cycle && !holdover_flag |=> !holdover_flag)
      else $error("phase hit on 8 kHz reference raised holdover");
endmodule // ref_monitor

// ===== bench/ref_source.sv
// Behavioural reference front end seen by one acquisition loop.
`timescale 1ns/1ns
module ref_source (
   // Clock
   input wire logic clk,
   // Controls from the bench
   input wire logic run,
   input wire logic fail,
   input wire logic [1:0] rate,
   // Front-end outputs
   output logic ref_cycle,
   output logic freq_fail,
   output logic range_exceed,
   output logic [1:0] rate_code
);
   logic [1:0] cnt_q = 2'h0;
   always_ff @(posedge clk) begin
      cnt_q <= cnt_q + 2'h1;
      ref_cycle <= run && cnt_q == 2'h0;
      freq_fail <= fail;
      range_exceed <= fail;
      rate_code <= rate;
   end
endmodule // ref_source

// ===== bench/test_sync_pll_mode_control.sv
// Self-checking bench for the PLL mode controller.
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
   $display("wrong value at %0t: %h %h", $time, a, b); end end
module test_sync_pll_mode_control;
   logic clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, pfail = 1'b0;
   logic prun = 1'b1, phit = 1'b0;
   logic [1:0] prate = 2'h3;
   logic [6:0] addr = 7'h00;
   logic [7:0] wdata = 8'h00, rdata, phase_offset;
   logic pri_ref_cycle, pri_freq_fail, pri_range_exceed, lock, holdover;
   logic sec_ref_cycle, sec_freq_fail, sec_range_exceed, free_run;
   logic [1:0] pri_rate_code, sec_rate_code;
   logic [15:0] core_freq, selected_ref_freq = 16'h0003;
   logic [31:0] osc_calibration_word;
   int fails = 0, n_checks = 0, cycles = 0;
   initial begin
      forever #25 clk = ~clk;
   end
   ref_source pri (.clk, .run(prun), .fail(pfail), .rate(prate),
      .ref_cycle(pri_ref_cycle), .freq_fail(pri_freq_fail),
      .range_exceed(pri_range_exceed), .rate_code(pri_rate_code));
   ref_source sec (.clk, .run(1'b1), .fail(1'b0), .rate(2'h1),
      .ref_cycle(sec_ref_cycle), .freq_fail(sec_freq_fail),
      .range_exceed(sec_range_exceed), .rate_code(sec_rate_code));
   sync_pll_mode_control #(.SLEW_HI_CYCLES(14'h0008),
      .FREQ_STEP_CYCLES(20'h00004)) dut (.clk, .reset, .addr, .wdata, .wr,
      .rd, .rdata, .pri_ref_cycle, .pri_freq_fail, .pri_phase_hit(phit),
      .pri_range_exceed, .pri_rate_code, .sec_ref_cycle, .sec_freq_fail,
      .sec_phase_hit(phit), .sec_range_exceed, .sec_rate_code,
      .selected_ref_freq, .lock, .holdover, .free_run, .phase_offset,
      .core_freq, .osc_calibration_word);
   task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 `CHK(rdata, e)
   endtask
   task automatic wait_lock(input int n);
      for (int i = 0; i < n && lock !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
   endtask
   task automatic stop_test;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic t_regs;
      rd_chk(7'h1a, 8'h00);
      rd_chk(7'h43, 8'h00);
      wr_reg(7'h40, 8'hff);
      wr_reg(7'h41, 8'he4);
      wr_reg(7'h42, 8'h83);
      wr_reg(7'h43, 8'h20);
      @(posedge clk);
      #1 `CHK(osc_calibration_word, 32'hffe48320)
      rd_chk(7'h41, 8'he4);
      rd_chk(7'h7f, 8'h00);
   endtask
   task automatic t_start;
      wr_reg(7'h00, 8'h00);
      repeat (3) @(posedge clk);
      #1 `CHK(holdover, 1'b1)
      wait_lock(2000);
      `CHK(lock, 1'b1)
      `CHK(core_freq, 16'h0003)
      rd_chk(7'h01, 8'h20);
      rd_chk(7'h20, 8'h18);
      rd_chk(7'h28, 8'h08);
   endtask
   task automatic t_fine;
      wr_reg(7'h00, 8'h04);
      wr_reg(7'h1a, 8'hff);
      repeat (12) @(posedge clk);
      #1 `CHK(phase_offset, 8'hff)
      wr_reg(7'h1a, 8'h01);
      repeat (4) @(posedge clk);
      #1 `CHK(phase_offset === 8'h01, 1'b0)
      repeat (30) @(posedge clk);
      #1 `CHK(phase_offset, 8'h01)
   endtask
   task automatic t_fail;
      @(posedge clk);
      pfail <= 1'b1;
      repeat (4) @(posedge clk);
      #1 `CHK({lock, holdover}, 2'b01)
      rd_chk(7'h20, 8'h1b);
      @(posedge clk);
      pfail <= 1'b0;
      repeat (150) @(posedge clk);
      #1 `CHK(lock, 1'b0)
      wait_lock(400);
      `CHK(lock, 1'b1)
   endtask
   task automatic t_manual;
      wr_reg(7'h19, 8'h02);
      pfail <= 1'b1;
      repeat (4) @(posedge clk);
      wr_reg(7'h19, 8'h06);
      wr_reg(7'h19, 8'h02);
      pfail <= 1'b0;
      repeat (400) @(posedge clk);
      #1 `CHK(lock, 1'b0)
      wr_reg(7'h19, 8'h06);
      wr_reg(7'h19, 8'h02);
      repeat (3) @(posedge clk);
      #1 `CHK(lock, 1'b1)
   endtask
   task automatic t_switch;
      wr_reg(7'h19, 8'h00);
      pfail <= 1'b1;
      repeat (6) @(posedge clk);
      #1 `CHK({lock, holdover}, 2'b01)
      wr_reg(7'h00, 8'h80);
      @(posedge clk);
      #1 `CHK({lock, holdover}, 2'b01)
      wait_lock(400);
      `CHK(lock, 1'b1)
      @(posedge clk);
      pfail <= 1'b0;
   endtask
   // Secondary is selected here; the primary loop is exercised on its own.
   task automatic t_hit;
      repeat (300) @(posedge clk);
      rd_chk(7'h20, 8'h18);
      @(posedge clk);
      prun <= 1'b0;
      repeat (2620) @(posedge clk);
      rd_chk(7'h20, 8'h1a);
      @(posedge clk);
      prun <= 1'b1;
      repeat (300) @(posedge clk);
      rd_chk(7'h20, 8'h18);
      @(posedge clk);
      phit <= 1'b1;
      prate <= 2'h2;
      repeat (4) @(posedge clk);
      phit <= 1'b0;
      rd_chk(7'h20, 8'h12);
      rd_chk(7'h28, 8'h08);
      `CHK(lock, 1'b1)
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         stop_test();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      #1 `CHK(free_run, 1'b1)
      t_regs();
      t_start();
      t_fine();
      t_fail();
      t_manual();
      t_switch();
      t_hit();
      stop_test();
   end
endmodule // test_sync_pll_mode_control
